// *** logic/adc_readout_pkg.sv ***
package adc_readout_pkg;
   localparam int RESULT_WIDTH = 16;
   localparam int FRAME_WIDTH = 18;
   localparam int FRAME_LEN_SELF = 18;
   localparam int FRAME_LEN_ECHO = 16;
   localparam int FRAME_COUNT_W = 5;
   localparam logic [1:0] HEADER_BITS = 2'h2;
   localparam logic [1:0] ECHO_PAD_BITS = 2'h0;

   localparam int CLOCK_PERIOD_NS = 10;
   localparam int CONVERSION_TIME_NS = 100;
   localparam int CONV_COUNT_W = 8;
   localparam int STRAP_SETTLE_CYCLES = 4;
   localparam int STRAP_COUNT_W = 3;

   localparam int APB_ADDR_W = 12;
   localparam logic [11:0] CONTROL_OFFSET = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;
   localparam logic [11:0] RESULT_OFFSET = 12'h008;
   localparam logic [11:0] COUNT_OFFSET = 12'h00C;

   localparam int CTRL_SOFT_START_BIT = 0;
   localparam int CTRL_CONVERT_DISABLE_BIT = 1;
   localparam logic [1:0] CONTROL_RESET = 2'h0;

   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_ECHO_MODE_BIT = 1;
   localparam int STAT_CMOS_BIT = 2;
   localparam int STAT_RESULT_VALID_BIT = 3;
   localparam int STAT_BW_NARROW_BIT = 4;
   localparam int STAT_VCM_ON_BIT = 5;
   localparam int STAT_CFG_A_BIT = 6;
   localparam int STAT_CFG_B_BIT = 7;
   localparam int STAT_OVERRUN_BIT = 8;
   localparam int STAT_STRAP_DONE_BIT = 9;

   localparam int PIN_SYNC_W = 7;
   localparam int PIN_CNV_P = 0;
   localparam int PIN_CNV_N = 1;
   localparam int PIN_ECHO = 2;
   localparam int PIN_CFG_A = 3;
   localparam int PIN_CFG_B = 4;
   localparam int PIN_BW = 5;
   localparam int PIN_VCM = 6;

   typedef enum logic {
      CONV_IDLE,
      CONV_BUSY
   } conv_state_e;
endpackage

// *** logic/link_serializer.sv ***
`timescale 1ns/1ns
module link_serializer (
   input wire logic shift_clock,
   input wire logic rst_b,
   input wire logic echo_mode,
   input wire logic [17:0] frame_word,
   input wire logic frame_toggle,
   output logic serial_bit,
   output logic start_toggle
);
   logic [1:0] mode_sync_reg;
   logic seen_toggle_reg;
   logic [17:0] shift_reg;
   logic [4:0] remain_reg;

   // Reset acts at once; a burst clock could not clock it out in time
   // Release is safe only because the host holds the clock idle then
   always_ff @(negedge shift_clock or negedge rst_b) begin
      if (!rst_b) begin
         mode_sync_reg <= 2'h0;
      end else begin
         mode_sync_reg <= {mode_sync_reg[0], echo_mode};
      end
   end

   // Word and toggle are held still while the host runs a burst
   always_ff @(negedge shift_clock or negedge rst_b) begin
      if (!rst_b) begin
         seen_toggle_reg <= 1'b0;
         shift_reg <= '0;
         remain_reg <= '0;
         serial_bit <= 1'b0;
         start_toggle <= 1'b0;
      end else if (frame_toggle != seen_toggle_reg) begin
         seen_toggle_reg <= frame_toggle;
         serial_bit <= frame_word[17];
         shift_reg <= {frame_word[16:0], 1'b0};
         remain_reg <= mode_sync_reg[1] ?
            5'(adc_readout_pkg::FRAME_LEN_ECHO - 1) :
            5'(adc_readout_pkg::FRAME_LEN_SELF - 1);
         start_toggle <= ~start_toggle;
      end else if (remain_reg != 5'h00) begin
         serial_bit <= shift_reg[17];
         shift_reg <= {shift_reg[16:0], 1'b0};
         remain_reg <= remain_reg - 5'h01;
      end else begin
         serial_bit <= 1'b0;
      end
   end
endmodule

// *** logic/adc_serial_result_readout.sv ***
`timescale 1ns/1ns
// Behaviour
// - Convert rising edge samples and starts conversion
// - Grounded negative leg means single-ended convert
// - Result leaves serially on data pair
// - One bit per shift clock falling edge
// - Grounded echo pin selects self-clocked readout
// - Self-clocked: leading 0, header 10, result
// - Echo mode: echo output copies shift clock
// - Launch on echo fall, host captures rise
// - Four static enable pins set configuration
// - Third enable pin selects input bandwidth
// - Fourth enable pin high enables common-mode output
// - Result MSB first, two's complement
// - Result readable after fixed conversion time
module adc_serial_result_readout #(
   parameter int CONVERSION_TIME_NS = adc_readout_pkg::CONVERSION_TIME_NS
) (
   input wire logic clock,
   input wire logic clock_enable,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic convert_start_p,
   input wire logic convert_start_n,
   input wire logic shift_clock_p,
   output logic data_out_p,
   output logic data_out_n,
   input wire logic echo_clock_out_p_in,
   output logic echo_clock_out_p_out,
   output logic echo_clock_out_p_oe,
   output logic echo_clock_out_n,
   input wire logic cfg_pin_a,
   input wire logic cfg_pin_b,
   input wire logic bandwidth_select,
   input wire logic common_mode_out_enable,
   input wire logic [15:0] conversion_code,
   output logic sample_now,
   output logic converting,
   output logic bandwidth_narrow,
   output logic common_mode_voltage_out,
   output logic [1:0] cfg_mode
);
   localparam int CONV_CYCLES_RAW =
      (CONVERSION_TIME_NS + adc_readout_pkg::CLOCK_PERIOD_NS - 1) /
      adc_readout_pkg::CLOCK_PERIOD_NS;
   localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
   localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);
   localparam logic [2:0] STRAP_LAST =
      3'(adc_readout_pkg::STRAP_SETTLE_CYCLES - 1);

   logic [6:0] pin_meta_reg;
   logic [6:0] pin_sync_reg;
   logic [6:0] pin_in;
   logic cnv_p_s;
   logic cnv_n_s;
   logic neg_leg_seen_reg;
   logic cmos_mode;
   logic cnv_level_reg;
   logic cnv_level_next;
   logic cnv_rise;
   logic [2:0] strap_count_reg;
   logic strap_done_reg;
   logic echo_mode_reg;
   adc_readout_pkg::conv_state_e conv_state_reg;
   logic [7:0] conv_count_reg;
   logic start_req;
   logic [1:0] control_reg;
   logic soft_start_reg;
   logic [15:0] result_reg;
   logic result_valid_reg;
   logic overrun_reg;
   logic [15:0] conv_total_reg;
   logic [17:0] frame_word_reg;
   logic frame_toggle_reg;
   logic leading_zero_reg;
   logic link_bit;
   logic link_start_toggle;
   logic [1:0] bit_sync_reg;
   logic [2:0] start_sync_reg;
   logic link_started;
   logic setup_phase;
   logic access_done;
   logic bus_write;
   logic bus_read;
   logic addr_known;
   logic [31:0] read_mux;
   logic [31:0] status_word;

   assign pin_in = {common_mode_out_enable, bandwidth_select, cfg_pin_b,
                    cfg_pin_a, echo_clock_out_p_in, convert_start_n,
                    convert_start_p};

   // Every pin is asynchronous to the register clock
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
      end else if (clock_enable) begin
         pin_meta_reg <= pin_in;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   assign cnv_p_s = pin_sync_reg[adc_readout_pkg::PIN_CNV_P];
   assign cnv_n_s = pin_sync_reg[adc_readout_pkg::PIN_CNV_N];

   // A differential pair drives its negative leg high at some point
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         neg_leg_seen_reg <= 1'b0;
      end else if (clock_enable && cnv_n_s) begin
         neg_leg_seen_reg <= 1'b1;
      end
   end
   assign cmos_mode = ~neg_leg_seen_reg;

   // Equal legs of a pair are a crossing, so the old level is kept
   always_comb begin
      cnv_level_next = cnv_level_reg;
      if (cmos_mode) begin
         cnv_level_next = cnv_p_s;
      end else if (cnv_p_s != cnv_n_s) begin
         cnv_level_next = cnv_p_s;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         cnv_level_reg <= 1'b0;
      end else if (clock_enable) begin
         cnv_level_reg <= cnv_level_next;
      end
   end
   assign cnv_rise = cnv_level_next & ~cnv_level_reg;

   // Mode strap read with the pin undriven, then locked
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         strap_count_reg <= '0;
         strap_done_reg <= 1'b0;
         echo_mode_reg <= 1'b0;
      end else if (clock_enable && !strap_done_reg) begin
         if (strap_count_reg == STRAP_LAST) begin
            strap_done_reg <= 1'b1;
            echo_mode_reg <=
               pin_sync_reg[adc_readout_pkg::PIN_ECHO];
         end else begin
            strap_count_reg <= strap_count_reg + 3'h1;
         end
      end
   end

   // Echo copy is the clock itself; a flop would halve it
   assign echo_clock_out_p_out = shift_clock_p & echo_mode_reg;
   assign echo_clock_out_n = ~echo_clock_out_p_out;

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         echo_clock_out_p_oe <= 1'b0;
      end else if (clock_enable) begin
         echo_clock_out_p_oe <= strap_done_reg & echo_mode_reg;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         bandwidth_narrow <= 1'b0;
         common_mode_voltage_out <= 1'b0;
         cfg_mode <= 2'h0;
      end else if (clock_enable) begin
         bandwidth_narrow <= pin_sync_reg[adc_readout_pkg::PIN_BW];
         common_mode_voltage_out <=
            pin_sync_reg[adc_readout_pkg::PIN_VCM];
         cfg_mode <= {pin_sync_reg[adc_readout_pkg::PIN_CFG_B],
                      pin_sync_reg[adc_readout_pkg::PIN_CFG_A]};
      end
   end

   assign start_req = strap_done_reg &
      ~control_reg[adc_readout_pkg::CTRL_CONVERT_DISABLE_BIT] &
      (cnv_rise | soft_start_reg);

   // Conversion timer; edges while busy are dropped and flagged
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         conv_state_reg <= adc_readout_pkg::CONV_IDLE;
         conv_count_reg <= '0;
         sample_now <= 1'b0;
         converting <= 1'b0;
      end else if (clock_enable) begin
         sample_now <= 1'b0;
         unique case (conv_state_reg)
            adc_readout_pkg::CONV_IDLE: begin
               if (start_req) begin
                  conv_state_reg <= adc_readout_pkg::CONV_BUSY;
                  conv_count_reg <= '0;
                  sample_now <= 1'b1;
                  converting <= 1'b1;
               end
            end
            adc_readout_pkg::CONV_BUSY: begin
               if (conv_count_reg == CONV_LAST) begin
                  conv_state_reg <= adc_readout_pkg::CONV_IDLE;
                  converting <= 1'b0;
               end else begin
                  conv_count_reg <= conv_count_reg + 8'h01;
               end
            end
         endcase
      end
   end

   // Result and frame formed straight at the end, no pipeline
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         result_reg <= '0;
         frame_word_reg <= '0;
         frame_toggle_reg <= 1'b0;
         conv_total_reg <= '0;
      end else if (clock_enable && conv_state_reg ==
                   adc_readout_pkg::CONV_BUSY && conv_count_reg == CONV_LAST)
      begin
         result_reg <= conversion_code;
         if (echo_mode_reg) begin
            frame_word_reg <= {conversion_code,
                               adc_readout_pkg::ECHO_PAD_BITS};
         end else begin
            frame_word_reg <= {adc_readout_pkg::HEADER_BITS,
                               conversion_code};
         end
         frame_toggle_reg <= ~frame_toggle_reg;
         conv_total_reg <= conv_total_reg + 16'h0001;
      end
   end

   link_serializer serializer (
      .shift_clock(shift_clock_p),
      .rst_b(rst_b),
      .echo_mode(echo_mode_reg),
      .frame_word(frame_word_reg),
      .frame_toggle(frame_toggle_reg),
      .serial_bit(link_bit),
      .start_toggle(link_start_toggle)
   );

   // Resync costs up to 30 ns, well inside half a link period
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         bit_sync_reg <= '0;
         start_sync_reg <= '0;
      end else if (clock_enable) begin
         bit_sync_reg <= {bit_sync_reg[0], link_bit};
         start_sync_reg <= {start_sync_reg[1:0], link_start_toggle};
      end
   end
   assign link_started = start_sync_reg[2] ^ start_sync_reg[1];

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         leading_zero_reg <= 1'b0;
      end else if (clock_enable) begin
         if (conv_state_reg == adc_readout_pkg::CONV_BUSY &&
             conv_count_reg == CONV_LAST) begin
            leading_zero_reg <= 1'b1;
         end else if (link_started) begin
            leading_zero_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         data_out_p <= 1'b0;
         data_out_n <= 1'b1;
      end else if (clock_enable) begin
         data_out_p <= ~leading_zero_reg & bit_sync_reg[1];
         data_out_n <= ~(~leading_zero_reg & bit_sync_reg[1]);
      end
   end

   assign setup_phase = psel & ~penable;
   assign access_done = psel & penable & pready;
   assign bus_write = access_done & pwrite;
   assign bus_read = access_done & ~pwrite;
   assign addr_known = (paddr == adc_readout_pkg::CONTROL_OFFSET) ||
                       (paddr == adc_readout_pkg::STATUS_OFFSET) ||
                       (paddr == adc_readout_pkg::RESULT_OFFSET) ||
                       (paddr == adc_readout_pkg::COUNT_OFFSET);

   always_comb begin
      status_word = '0;
      status_word[adc_readout_pkg::STAT_BUSY_BIT] = converting;
      status_word[adc_readout_pkg::STAT_ECHO_MODE_BIT] = echo_mode_reg;
      status_word[adc_readout_pkg::STAT_CMOS_BIT] = cmos_mode;
      status_word[adc_readout_pkg::STAT_RESULT_VALID_BIT] = result_valid_reg;
      status_word[adc_readout_pkg::STAT_BW_NARROW_BIT] = bandwidth_narrow;
      status_word[adc_readout_pkg::STAT_VCM_ON_BIT] = common_mode_voltage_out;
      status_word[adc_readout_pkg::STAT_CFG_A_BIT] = cfg_mode[0];
      status_word[adc_readout_pkg::STAT_CFG_B_BIT] = cfg_mode[1];
      status_word[adc_readout_pkg::STAT_OVERRUN_BIT] = overrun_reg;
      status_word[adc_readout_pkg::STAT_STRAP_DONE_BIT] = strap_done_reg;
   end

   always_comb begin
      read_mux = '0;
      unique case (paddr)
         adc_readout_pkg::CONTROL_OFFSET: read_mux = {30'h0, control_reg};
         adc_readout_pkg::STATUS_OFFSET: read_mux = status_word;
         adc_readout_pkg::RESULT_OFFSET: read_mux = {16'h0, result_reg};
         adc_readout_pkg::COUNT_OFFSET: read_mux = {16'h0, conv_total_reg};
         default: read_mux = '0;
      endcase
   end

   // One wait-free access cycle; answer is set up during setup
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else if (clock_enable) begin
         pready <= setup_phase;
         pslverr <= setup_phase & ~addr_known;
         prdata <= (setup_phase & ~pwrite) ? read_mux : 32'h0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         control_reg <= adc_readout_pkg::CONTROL_RESET;
         soft_start_reg <= 1'b0;
      end else if (clock_enable) begin
         soft_start_reg <= 1'b0;
         if (bus_write && paddr == adc_readout_pkg::CONTROL_OFFSET) begin
            control_reg[adc_readout_pkg::CTRL_CONVERT_DISABLE_BIT] <=
               pwdata[adc_readout_pkg::CTRL_CONVERT_DISABLE_BIT];
            soft_start_reg <= pwdata[adc_readout_pkg::CTRL_SOFT_START_BIT];
         end
      end
   end

   // Hardware set wins over a same-cycle software clear
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         result_valid_reg <= 1'b0;
         overrun_reg <= 1'b0;
      end else if (clock_enable) begin
         if (conv_state_reg == adc_readout_pkg::CONV_BUSY &&
             conv_count_reg == CONV_LAST) begin
            result_valid_reg <= 1'b1;
         end else if (bus_read &&
                      paddr == adc_readout_pkg::RESULT_OFFSET) begin
            result_valid_reg <= 1'b0;
         end
         if (conv_state_reg == adc_readout_pkg::CONV_BUSY && cnv_rise) begin
            overrun_reg <= 1'b1;
         end else if (bus_write &&
                      paddr == adc_readout_pkg::STATUS_OFFSET &&
                      pwdata[adc_readout_pkg::STAT_OVERRUN_BIT]) begin
            overrun_reg <= 1'b0;
         end
      end
   end
endmodule

// *** dv/adc_readout_asserts.sv ***
`timescale 1ns/1ns
module adc_readout_asserts #(
   parameter int CONVERSION_TIME_NS = 100
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic shift_clock_p,
   input wire logic data_out_p,
   input wire logic data_out_n,
   input wire logic echo_clock_out_p_out,
   input wire logic echo_clock_out_p_oe,
   input wire logic echo_clock_out_n,
   input wire logic cfg_pin_a,
   input wire logic cfg_pin_b,
   input wire logic bandwidth_select,
   input wire logic common_mode_out_enable,
   input wire logic sample_now,
   input wire logic converting,
   input wire logic bandwidth_narrow,
   input wire logic common_mode_voltage_out,
   input wire logic [1:0] cfg_mode
);
   localparam int CONV_CYCLES =
      CONVERSION_TIME_NS / adc_readout_pkg::CLOCK_PERIOD_NS;
   logic [7:0] conv_len_reg;
   // Length of the current busy stretch
   always_ff @(posedge clock) begin
      if (!rst_b || !converting) begin
         conv_len_reg <= 8'h00;
      end else begin
         conv_len_reg <= conv_len_reg + 8'h01;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   a_start_busy: assert property (sample_now |-> converting)
      else $error("start pulse without busy");
   a_conv_length: assert property ($fell(converting) |->
      conv_len_reg == CONV_CYCLES) else $error("wrong conversion time");
   a_data_pair: assert property (data_out_n == !data_out_p)
      else $error("data pair not complementary");
   a_echo_copy: assert property (echo_clock_out_p_oe |->
      echo_clock_out_p_out == shift_clock_p) else $error("echo not a copy");
   a_echo_pair: assert property (echo_clock_out_n ==
      !echo_clock_out_p_out) else $error("echo pair not complementary");
   // Pins may settle through synchronisers, so allow a few edges
   a_bw_follow: assert property ($stable(bandwidth_select)[*6] |->
      bandwidth_narrow == bandwidth_select) else $error("bandwidth wrong");
   a_vcm_follow: assert property (
      $stable(common_mode_out_enable)[*6] |->
      common_mode_voltage_out == common_mode_out_enable)
      else $error("common mode output wrong");
   a_cfg_follow: assert property (
      $stable({cfg_pin_b, cfg_pin_a})[*6] |->
      cfg_mode == {cfg_pin_b, cfg_pin_a})
      else $error("config mode wrong");
   a_apb_answer: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   c_started: cover property (sample_now);
   c_conv_end: cover property ($fell(converting));
   c_echo_on: cover property ($rose(echo_clock_out_p_oe));
   c_refused: cover property (pready && pslverr);
endmodule
bind adc_serial_result_readout adc_readout_asserts #(
   .CONVERSION_TIME_NS(CONVERSION_TIME_NS)
) i_adc_readout_asserts (
   .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .shift_clock_p(shift_clock_p),
   .data_out_p(data_out_p), .data_out_n(data_out_n),
   .echo_clock_out_p_out(echo_clock_out_p_out),
   .echo_clock_out_p_oe(echo_clock_out_p_oe),
   .echo_clock_out_n(echo_clock_out_n), .cfg_pin_a(cfg_pin_a),
   .cfg_pin_b(cfg_pin_b), .bandwidth_select(bandwidth_select),
   .common_mode_out_enable(common_mode_out_enable),
   .sample_now(sample_now), .converting(converting),
   .bandwidth_narrow(bandwidth_narrow),
   .common_mode_voltage_out(common_mode_voltage_out),
   .cfg_mode(cfg_mode)
);

// *** dv/host_link_model.sv ***
`timescale 1ns/1ns
module host_link_model (
   output logic shift_clock_p,
   input wire logic data_out_p
);
   // Idles high; moves only inside a burst
   initial shift_clock_p = 1'b1;
   // One whole frame per call, length chosen by caller
   task automatic burst(input int n, output logic [17:0] got);
      got = 18'h00000;
      for (int i = 0; i < n; i++) begin
         #61 shift_clock_p = 1'b0;
         #63 shift_clock_p = 1'b1;
         // Taken just after the rise; header 1 aligns the word
         #1 got = {got[16:0], data_out_p};
      end
   endtask
endmodule

// *** dv/tb_adc_serial_result_readout.sv ***
`timescale 1ns/1ns
module tb_adc_serial_result_readout;
   logic clock, rst_b, psel, penable, pwrite, pready, pslverr, echo_pin;
   logic convert_start_p, convert_start_n, shift_clock_p, data_out_p;
   logic echo_strap, echo_clock_out_p_out, echo_clock_out_p_oe, converting;
   logic bandwidth_narrow, common_mode_voltage_out;
   logic [1:0] cfg_mode;
   logic [3:0] en_pins;
   logic [11:0] paddr;
   logic [15:0] conversion_code;
   logic [31:0] pwdata, prdata;
   int bad_count, checks;
   // Strap pull decides the mode while the pin is not driven
   assign echo_pin = echo_clock_out_p_oe ? echo_clock_out_p_out : echo_strap;
   adc_serial_result_readout i_adc_serial_result_readout (
      .clock(clock), .clock_enable(1'b1), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .convert_start_p(convert_start_p), .convert_start_n(convert_start_n),
      .shift_clock_p(shift_clock_p), .data_out_p(data_out_p),
      .data_out_n(), .echo_clock_out_p_in(echo_pin),
      .echo_clock_out_p_out(echo_clock_out_p_out),
      .echo_clock_out_p_oe(echo_clock_out_p_oe), .echo_clock_out_n(),
      .cfg_pin_a(en_pins[0]), .cfg_pin_b(en_pins[1]),
      .bandwidth_select(en_pins[2]), .common_mode_out_enable(en_pins[3]),
      .conversion_code(conversion_code), .sample_now(),
      .converting(converting), .bandwidth_narrow(bandwidth_narrow),
      .common_mode_voltage_out(common_mode_voltage_out), .cfg_mode(cfg_mode)
   );
   host_link_model i_host_link_model (
      .shift_clock_p(shift_clock_p),
      .data_out_p(data_out_p)
   );
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
                      output logic [31:0] rd, output logic err);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= 32'hFFFFFFFF;
      @(posedge clock);
      penable <= 1'b1;
      // Slave latency is not assumed; the watchdog bounds the wait
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Link side resets at once, so no shift edges are needed here
   task automatic do_reset(input logic strap, input logic neg);
      @(posedge clock);
      rst_b <= 1'b0;
      echo_strap <= strap;
      convert_start_n <= neg;
      repeat (10) @(posedge clock);
      rst_b <= 1'b1;
      repeat (12) @(posedge clock);
   endtask
   task automatic convert(input logic diff);
      @(posedge clock);
      convert_start_p <= 1'b1;
      convert_start_n <= 1'b0;
      repeat (5) @(posedge clock);
      convert_start_p <= 1'b0;
      convert_start_n <= diff;
      while (converting !== 1'b0) @(posedge clock);
      repeat (3) @(posedge clock);
   endtask
   task automatic t_self;
      logic [17:0] got;
      logic [31:0] rd;
      logic [31:0] want;
      logic err;
      do_reset(1'b0, 1'b0);
      // Codes end in 1 so a stale last bit would spoil the leading 0
      for (int k = 0; k < 2; k++) begin
         conversion_code <= k ? 16'h7FFF : 16'h8001;
         convert(1'b0);
         check("lead", 32'(data_out_p), 32'h0);
         i_host_link_model.burst(18, got);
         want = {14'h0, 2'h2, conversion_code};
         check("self", 32'(got), want);
      end
      apb(1'b0, adc_readout_pkg::STATUS_OFFSET, rd, err);
      check("mode", 32'(rd[2:1]), 32'h2);
      apb(1'b0, adc_readout_pkg::RESULT_OFFSET, rd, err);
      check("result", rd, 32'h00007FFF);
      apb(1'b0, adc_readout_pkg::COUNT_OFFSET, rd, err);
      check("count", rd, 32'h00000002);
      apb(1'b1, 12'h010, rd, err);
      check("unmapped", {31'h0, err}, 32'h1);
   endtask
   task automatic t_static;
      for (int i = 0; i < 16; i++) begin
         en_pins <= 4'(i);
         repeat (8) @(posedge clock);
         check("bw", 32'(bandwidth_narrow), 32'(en_pins[2]));
         check("vcm", 32'(common_mode_voltage_out),
               32'(en_pins[3]));
         check("cfg", 32'(cfg_mode), 32'(en_pins[1:0]));
      end
   endtask
   task automatic t_echo;
      logic [17:0] got;
      logic [31:0] rd;
      logic err;
      do_reset(1'b1, 1'b1);
      check("echo oe", 32'(echo_clock_out_p_oe), 32'h1);
      conversion_code <= 16'h1234;
      convert(1'b1);
      i_host_link_model.burst(16, got);
      check("echo", 32'(got), 32'h00001234);
      apb(1'b0, adc_readout_pkg::STATUS_OFFSET, rd, err);
      check("mode", 32'(rd[2:1]), 32'h1);
   endtask
   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      convert_start_p = 1'b0;
      convert_start_n = 1'b0;
      echo_strap = 1'b0;
      en_pins = 4'h0;
      conversion_code = 16'h0000;
      bad_count = 0;
      checks = 0;
      t_self;
      t_static;
      t_echo;
      give_verdict;
   end
   // Whole run needs well under 40 us
   initial begin
      #200000;
      bad_count++;
      give_verdict;
   end
endmodule
